/* File: logic/oos_seq.sv */
`timescale 1ns/1ps
`include "oos_cfg.svh"
module oos_seq #(
  parameter int CYC_PER_MS = `OOS_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Command port
  input  wire logic                  cmd_valid_i,
  output logic                       cmd_ready_o,
  input  wire logic                  cmd_write_i,
  input  wire logic [7:0]            cmd_code_i,
  input  wire logic                  cmd_page_i,
  input  wire oos_pkg::oos_word_t    cmd_wdata_i,
  input  wire logic                  clear_faults_i,
  output logic                       rsp_valid_o,
  output oos_pkg::oos_word_t         rsp_data_o,
  // Output control
  input  wire logic [1:0]            enable_i,
  input  wire logic                  multi_phase_i,
  input  wire oos_pkg::oos_word_t    mp_ramp_gain_i,
  // Fault events per output
  input  wire logic [1:0]            ov_fault_i,
  input  wire logic [1:0]            oc_fault_i,
  input  wire logic [1:0]            vin_uv_fault_i,
  input  wire logic [1:0]            temp_fault_i,
  input  wire logic [1:0]            comm_memory_logic_fault_i,
  input  wire logic [1:0]            other_fault_i,
  // Power stage
  output logic [1:0]                 switch_on_o,
  output logic [1:0]                 ramp_up_o,
  output logic [1:0]                 ramp_down_o
);
  // Linear-11 to 1/128 ms units, clamped; negative reads as zero
  function automatic oos_pkg::oos_units_t lin_units(input logic [15:0] v);
    logic [5:0]  sh;
    logic [39:0] w;
    sh = {v[`OOS_L11_EXP_MSB], v[`OOS_L11_EXP_MSB:`OOS_L11_EXP_LSB]}
         + 6'(`OOS_UNIT_SHIFT); // R21
    w  = 40'(v[`OOS_L11_MANT_MSB-1:0]);
    if (v[`OOS_L11_MANT_MSB]) begin
      w = 40'h00_0000_0000;
    end else if (sh[5]) begin
      w = w >> (6'(~sh) + 6'h01);
    end else begin
      w = w << sh[4:0]; // R3
    end
    lin_units = (|w[39:23]) ? 23'h7F_FFFF : w[22:0];
  endfunction : lin_units

  // Command code to storage index
  function automatic logic [2:0] code_idx(input logic [7:0] code);
    case (code)
      `OOS_CODE_ON_DLY:   code_idx = 3'h4;
      `OOS_CODE_ON_RISE:  code_idx = 3'h5;
      `OOS_CODE_OFF_DLY:  code_idx = 3'h6;
      `OOS_CODE_OFF_FALL: code_idx = 3'h7;
      default:            code_idx = 3'h0;
    endcase
  endfunction : code_idx

  localparam oos_pkg::oos_units_t FALL_MIN = 23'(`OOS_FALL_MIN_UNITS);

  logic [7:0][15:0]          words;
  oos_pkg::oos_word_t        mem_rd;
  logic [17:0]               acc_r;
  logic                      tick_r;
  logic                      rd1_r;
  logic                      rd1_stat_r;
  logic                      rd1_page_r;
  logic                      rd1_hit_r;
  logic [1:0][7:0]           stat_r;
  logic [1:0]                off_bit;
  oos_pkg::oos_state_e [1:0] st_r;
  oos_pkg::oos_units_t [1:0] cnt_r;
  oos_pkg::oos_units_t [1:0] rise_u;
  logic [1:0]                fast_off;
  logic [1:0]                cnt_zero;
  logic                      taken;
  logic                      refused;
  logic [2:0]                cidx;
  logic                      wr_ok;
  logic [1:0][7:0]           ev;

  // Fractional divider: average of 128 ticks per ms without a non-integer count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r  <= 18'h0_0000;
      tick_r <= 1'b0;
    end else if (acc_r + 18'(`OOS_UNITS_PER_MS) >= 18'(CYC_PER_MS)) begin
      acc_r  <= acc_r + 18'(`OOS_UNITS_PER_MS) - 18'(CYC_PER_MS);
      tick_r <= 1'b1;
    end else begin
      acc_r  <= acc_r + 18'(`OOS_UNITS_PER_MS);
      tick_r <= 1'b0;
    end
  end

  // Command decode; a read in flight makes the next command a busy fault
  assign cmd_ready_o = !rd1_r;
  assign taken       = cmd_valid_i && cmd_ready_o;
  assign refused     = cmd_valid_i && !cmd_ready_o;
  assign cidx        = code_idx(cmd_code_i);
  assign wr_ok       = taken && cmd_write_i && cidx[2];

  oos_regmem u_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (wr_ok),
    .wr_addr_i ({cmd_page_i, cidx[1:0]}), // R13
    .wr_data_i (cmd_wdata_i),
    .rd_addr_i ({cmd_page_i, cidx[1:0]}),
    .rd_data_o (mem_rd),
    .words_o   (words)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd1_r      <= 1'b0;
      rd1_stat_r <= 1'b0;
      rd1_page_r <= 1'b0;
      rd1_hit_r  <= 1'b0;
    end else begin
      rd1_r      <= taken && !cmd_write_i;
      rd1_stat_r <= cmd_code_i == `OOS_CODE_STATUS;
      rd1_page_r <= cmd_page_i;
      rd1_hit_r  <= cidx[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 16'h0000;
    end else begin
      rsp_valid_o <= rd1_r;
      if (rd1_stat_r) begin
        rsp_data_o <= {8'h00, stat_r[rd1_page_r] | {1'b0, off_bit[rd1_page_r], 6'h00}}; // R19
      end else if (rd1_hit_r) begin
        rsp_data_o <= mem_rd;
      end else begin
        rsp_data_o <= 16'h0000;
      end
    end
  end

  // Per-output sequencing
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      rise_u[g]   = multi_phase_i ? lin_units(mp_ramp_gain_i)
                                  : lin_units(words[g*4+1]); // R4 R5
      fast_off[g] = multi_phase_i || (lin_units(words[g*4+3]) < FALL_MIN); // R10 R11
      cnt_zero[g] = cnt_r[g] == 23'h00_0000;
      off_bit[g]  = (st_r[g] == oos_pkg::ST_OFF) || (st_r[g] == oos_pkg::ST_ON_DLY); // R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < 2; g++) begin
        st_r[g] <= oos_pkg::ST_OFF;
      end
      cnt_r <= '0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        case (st_r[g])
          oos_pkg::ST_OFF: begin
            if (enable_i[g]) begin
              st_r[g]  <= oos_pkg::ST_ON_DLY;
              cnt_r[g] <= lin_units(words[g*4]); // R1
            end
          end
          oos_pkg::ST_ON_DLY: begin
            if (!enable_i[g]) begin
              st_r[g] <= oos_pkg::ST_OFF;
            end else if (cnt_zero[g]) begin
              st_r[g]  <= oos_pkg::ST_RISE; // R1
              cnt_r[g] <= rise_u[g];
            end else if (tick_r) begin
              cnt_r[g] <= cnt_r[g] - 23'h00_0001;
            end
          end
          oos_pkg::ST_RISE: begin
            if (!enable_i[g]) begin
              st_r[g]  <= oos_pkg::ST_OFF_DLY;
              cnt_r[g] <= lin_units(words[g*4+2]);
            end else if (cnt_zero[g]) begin
              st_r[g] <= oos_pkg::ST_ON;
            end else if (tick_r) begin
              cnt_r[g] <= cnt_r[g] - 23'h00_0001;
            end
          end
          oos_pkg::ST_ON: begin
            if (!enable_i[g]) begin
              st_r[g]  <= oos_pkg::ST_OFF_DLY;
              cnt_r[g] <= lin_units(words[g*4+2]); // R7 R8
            end
          end
          oos_pkg::ST_OFF_DLY: begin
            if (enable_i[g]) begin
              st_r[g] <= oos_pkg::ST_ON;
            end else if (cnt_zero[g]) begin
              st_r[g]  <= fast_off[g] ? oos_pkg::ST_OFF : oos_pkg::ST_FALL; // R10 R11
              cnt_r[g] <= lin_units(words[g*4+3]); // R9
            end else if (tick_r) begin
              cnt_r[g] <= cnt_r[g] - 23'h00_0001; // R7
            end
          end
          oos_pkg::ST_FALL: begin
            if (enable_i[g]) begin
              st_r[g]  <= oos_pkg::ST_ON_DLY;
              cnt_r[g] <= lin_units(words[g*4]);
            end else if (cnt_zero[g]) begin
              st_r[g] <= oos_pkg::ST_OFF;
            end else if (tick_r) begin
              cnt_r[g] <= cnt_r[g] - 23'h00_0001;
            end
          end
          default: begin
            st_r[g] <= oos_pkg::ST_OFF;
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int g = 0; g < 2; g++) begin
      switch_on_o[g] = !off_bit[g];
      ramp_up_o[g]   = st_r[g] == oos_pkg::ST_RISE;
      ramp_down_o[g] = st_r[g] == oos_pkg::ST_FALL;
    end
  end

  // Fault events per page; a new event wins over clear-faults below
  always_comb begin
    ev = '0;
    for (int g = 0; g < 2; g++) begin
      ev[g][`OOS_ST_BUSY]   = refused && (cmd_page_i == 1'(g)); // R14
      ev[g][`OOS_ST_OV]     = ov_fault_i[g]; // R16
      ev[g][`OOS_ST_OC]     = oc_fault_i[g];
      ev[g][`OOS_ST_VIN_UV] = vin_uv_fault_i[g];
      ev[g][`OOS_ST_TEMP]   = temp_fault_i[g]; // R17
      // Writes to unknown or read-only codes count as logic faults
      ev[g][`OOS_ST_CML]    = comm_memory_logic_fault_i[g] || (taken && cmd_write_i
                              && !cidx[2] && (cmd_page_i == 1'(g)));
      ev[g][`OOS_ST_OTHER]  = other_fault_i[g]; // R18
    end
  end

  // Sticky fault summary, cleared only on request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= {`OOS_RST_STATUS, `OOS_RST_STATUS}; // R19
    end else begin
      for (int g = 0; g < 2; g++) begin
        stat_r[g] <= (clear_faults_i ? 8'h00 : stat_r[g]) | ev[g]; // R20
      end
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chk
      property p_on_wait;
        @(posedge clk_i) disable iff (rst_i)
          (st_r[g] == oos_pkg::ST_ON_DLY) && !cnt_zero[g] |=> st_r[g] != oos_pkg::ST_RISE;
      endproperty
      a_on_wait: assert property (p_on_wait) // R1
        else $error("rise started before turn-on delay ended");

      property p_rise_len;
        @(posedge clk_i) disable iff (rst_i)
          $rose(ramp_up_o[g]) |-> cnt_r[g] == ($past(multi_phase_i)
            ? lin_units($past(mp_ramp_gain_i)) : lin_units($past(words[g*4+1])));
      endproperty
      a_rise_len: assert property (p_rise_len) // R5
        else $error("rise length from wrong source");

      property p_off_wait;
        @(posedge clk_i) disable iff (rst_i)
          (st_r[g] == oos_pkg::ST_OFF_DLY) && !cnt_zero[g] && !enable_i[g]
          |=> st_r[g] == oos_pkg::ST_OFF_DLY;
      endproperty
      a_off_wait: assert property (p_off_wait) // R7
        else $error("fall started before turn-off delay ended");

      property p_fast_off;
        @(posedge clk_i) disable iff (rst_i)
          (st_r[g] == oos_pkg::ST_OFF_DLY) && cnt_zero[g] && !enable_i[g] && fast_off[g]
          |=> !switch_on_o[g] && !ramp_down_o[g];
      endproperty
      a_fast_off: assert property (p_fast_off) // R11
        else $error("switches not off right after turn-off delay");

      property p_off_bit;
        @(posedge clk_i) disable iff (rst_i)
          rd1_r && rd1_stat_r && (rd1_page_r == 1'(g))
          |=> rsp_data_o[`OOS_ST_OFF] == $past(!switch_on_o[g]);
      endproperty
      a_off_bit: assert property (p_off_bit) // R15
        else $error("off bit does not follow output power");

      property p_ov_sticky;
        @(posedge clk_i) disable iff (rst_i)
          ov_fault_i[g] |=> stat_r[g][`OOS_ST_OV]
          ##1 (stat_r[g][`OOS_ST_OV] || $past(clear_faults_i));
      endproperty
      a_ov_sticky: assert property (p_ov_sticky) // R16
        else $error("overvoltage bit not latched");

      property p_hold;
        @(posedge clk_i) disable iff (rst_i)
          stat_r[g][`OOS_ST_TEMP] && !clear_faults_i |=> stat_r[g][`OOS_ST_TEMP];
      endproperty
      a_hold: assert property (p_hold) // R20
        else $error("fault bit dropped without clear");

      property p_fall_len;
        @(posedge clk_i) disable iff (rst_i)
          $rose(ramp_down_o[g]) |-> cnt_r[g] == lin_units($past(words[g*4+3]));
      endproperty
      a_fall_len: assert property (p_fall_len) // R9
        else $error("fall length not from fall-time setting");
    end
  endgenerate

  property p_busy;
    @(posedge clk_i) disable iff (rst_i)
      refused && !cmd_page_i |=> stat_r[0][`OOS_ST_BUSY];
  endproperty
  a_busy: assert property (p_busy) // R14
    else $error("busy fault not flagged");

  property p_bad_write;
    @(posedge clk_i) disable iff (rst_i)
      taken && cmd_write_i && (cmd_code_i == `OOS_CODE_STATUS) && cmd_page_i
      |=> stat_r[1][`OOS_ST_CML];
  endproperty
  a_bad_write: assert property (p_bad_write) // R17
    else $error("write to read-only status not flagged");

  property p_read_lat;
    @(posedge clk_i) disable iff (rst_i)
      taken && !cmd_write_i |-> ##2 rsp_valid_o;
  endproperty
  a_read_lat: assert property (p_read_lat) // R19
    else $error("read answer missing");
endmodule : oos_seq

/* File: inc/oos_cfg.svh */
`ifndef OOS_CFG_SVH
`define OOS_CFG_SVH
// Overview of operation
// R1: Turn-on delay counted from enable before rise
// R2: Turn-on delay resets 10 ms first, 5 ms second
// R3: Rise time is Linear-11 milliseconds
// R4: Rise time sets ramp in single or dual mode
// R5: Stacked phases take ramp from multi-phase gain
// R6: Host keeps rise time 0 to 100 ms
// R7: Turn-off delay counted from disable before fall
// R8: Turn-off delay spans zero to five seconds
// R9: Fall time sets ramp-down in one/two phase
// R10: Fall below 0.5 ms switches off immediately
// R11: Stacked phases always switch off immediately
// R12: Rise, off delay, fall reset to 5 ms
// R13: Settings and status held per output page
// R14: Bit 7 flags fault from busy device
// R15: Bit 6 high while output delivers no power
// R16: Bits 5,4,3 flag overvoltage, overcurrent, input undervoltage
// R17: Bit 2 temperature, bit 1 comm/memory/logic
// R18: Bit 0 flags any other fault
// R19: Status byte read-only, resets to zero
// R20: Latched fault bits cleared only by clear-faults
// R21: Linear-11 exponent 15:11, mantissa 10:0, signed

`define OOS_CODE_ON_DLY   8'h60
`define OOS_CODE_ON_RISE  8'h61
`define OOS_CODE_OFF_DLY  8'h64
`define OOS_CODE_OFF_FALL 8'h65
`define OOS_CODE_STATUS   8'h78

`define OOS_RST_ON_DLY_P0 16'hD280
`define OOS_RST_TIMING    16'hCA80
`define OOS_RST_STATUS    8'h00

`define OOS_L11_EXP_MSB   15
`define OOS_L11_EXP_LSB   11
`define OOS_L11_MANT_MSB  10

`define OOS_ST_BUSY       7
`define OOS_ST_OFF        6
`define OOS_ST_OV         5
`define OOS_ST_OC         4
`define OOS_ST_VIN_UV     3
`define OOS_ST_TEMP       2
`define OOS_ST_CML        1
`define OOS_ST_OTHER      0

`define OOS_CLK_MHZ       200
`define OOS_CYC_PER_MS    (`OOS_CLK_MHZ * 1000)
`define OOS_UNITS_PER_MS  128
`define OOS_UNIT_SHIFT    7
`define OOS_FALL_MIN_US   500
`define OOS_FALL_MIN_UNITS ((`OOS_FALL_MIN_US * `OOS_UNITS_PER_MS + 999) / 1000)
`endif

/* File: inc/oos_pkg.sv */
package oos_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_DLY,
    ST_RISE,
    ST_ON,
    ST_OFF_DLY,
    ST_FALL
  } oos_state_e;
  typedef logic [22:0] oos_units_t;
  typedef logic [15:0] oos_word_t;
endpackage : oos_pkg

/* File: logic/oos_regmem.sv */
`timescale 1ns/1ps
`include "oos_cfg.svh"
module oos_regmem (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Write port, address is {page, index}
  input  wire logic                  wr_en_i,
  input  wire logic [2:0]            wr_addr_i,
  input  wire oos_pkg::oos_word_t    wr_data_i,
  // Read port
  input  wire logic [2:0]            rd_addr_i,
  output oos_pkg::oos_word_t         rd_data_o,
  // All words for the sequencers
  output logic [7:0][15:0]           words_o
);
  logic [7:0][15:0] mem_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= `OOS_RST_TIMING; // R12
      end
      mem_r[0] <= `OOS_RST_ON_DLY_P0; // R2
    end else if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i; // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

  assign words_o = mem_r;

  property p_reset_defaults;
    @(posedge clk_i) rst_i |=> (mem_r[0] == 16'hD280) && (mem_r[4] == 16'hCA80)
      && (mem_r[1] == 16'hCA80) && (mem_r[7] == 16'hCA80);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) // R2
    else $error("timing defaults wrong after reset");
endmodule : oos_regmem

/* File: dv/oos_host_model.sv */
`timescale 1ns/1ps
module oos_host_model (
  // Clock
  input  wire logic        clk_i,
  // Command port
  output logic             cmd_valid_o,
  input  wire logic        cmd_ready_i,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic             cmd_page_o,
  output logic [15:0]      cmd_wdata_o,
  input  wire logic        rsp_valid_i,
  input  wire logic [15:0] rsp_data_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_page_o  = 1'b0;
    cmd_wdata_o = 16'h0000;
  end

  // Ready is steady between edges, so the low phase shows what the next edge takes
  task automatic issue(input logic w, input logic [7:0] c, input logic p, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_code_o  <= c;
    cmd_page_o  <= p;
    cmd_wdata_o <= d;
    @(negedge clk_i);
    while (cmd_ready_i !== 1'b1) begin
      k++;
      if (k > 8) oos_seq_tb_top.time_out();
      @(negedge clk_i);
    end
    @(posedge clk_i);
  endtask : issue

  // Released lines flip so stale values never look valid
  task automatic drop();
    cmd_valid_o <= 1'b0;
    cmd_write_o <= ~cmd_write_o;
    cmd_code_o  <= ~cmd_code_o;
    cmd_page_o  <= ~cmd_page_o;
    cmd_wdata_o <= ~cmd_wdata_o;
  endtask : drop

  task automatic wait_rsp(output logic [15:0] d);
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
      if (k > 8) oos_seq_tb_top.time_out();
    end while (rsp_valid_i !== 1'b1);
    d = rsp_data_i;
  endtask : wait_rsp

  // Callers only hand rise words inside 0 to 100 ms
  task automatic write_cmd(input logic [7:0] c, input logic p, input logic [15:0] d);
    issue(1'b1, c, p, d);
    drop();
  endtask : write_cmd

  task automatic read_cmd(input logic [7:0] c, input logic p, output logic [15:0] d);
    issue(1'b0, c, p, 16'h0000);
    drop();
    wait_rsp(d);
  endtask : read_cmd

  // Deliberately keeps a write up in the cycle after a read is taken
  task automatic busy_read(input logic p, output logic [15:0] d);
    issue(1'b0, 8'h78, p, 16'h0000);
    cmd_write_o <= 1'b1;
    cmd_code_o  <= 8'h60;
    cmd_wdata_o <= 16'h0000;
    @(posedge clk_i);
    drop();
    wait_rsp(d);
  endtask : busy_read
endmodule : oos_host_model

/* File: dv/oos_seq_tb_top.sv */
`timescale 1ns/1ps
module oos_seq_tb_top;
  logic               clk_i, rst_i, cmd_valid, cmd_ready, cmd_write, cmd_page;
  logic               clear_faults, rsp_valid, multi_phase, any_dn;
  logic [7:0]         cmd_code;
  oos_pkg::oos_word_t cmd_wdata, rsp_data, mp_gain;
  logic [1:0]         enable, sw, up, dn;
  logic [1:0]         flt [6];
  int                 failures, n_tests;

  oos_host_model i_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
    .cmd_write_o(cmd_write), .cmd_code_o(cmd_code), .cmd_page_o(cmd_page),
    .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data));

  // Short ms so each t_seq sequence takes a few hundred cycles
  oos_seq #(.CYC_PER_MS(256)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
    .cmd_code_i(cmd_code), .cmd_page_i(cmd_page), .cmd_wdata_i(cmd_wdata),
    .clear_faults_i(clear_faults), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .enable_i(enable), .multi_phase_i(multi_phase), .mp_ramp_gain_i(mp_gain),
    .ov_fault_i(flt[0]), .oc_fault_i(flt[1]), .vin_uv_fault_i(flt[2]),
    .temp_fault_i(flt[3]), .comm_memory_logic_fault_i(flt[4]), .other_fault_i(flt[5]),
    .switch_on_o(sw), .ramp_up_o(up), .ramp_down_o(dn));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic time_out();
    failures++;
    wrap_up();
  endtask : time_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Tick divider jitters by a cycle or two, so counts get a window
  task automatic near(input int n, input int e);
    check((n >= e - 4 && n <= e + 6) ? 16'(e) : 16'(n), 16'(e));
  endtask : near

  task automatic rd_chk(input logic [7:0] c, input logic p, input logic [15:0] e);
    logic [15:0] d;
    i_host.read_cmd(c, p, d);
    check(d, e);
  endtask : rd_chk

  function automatic logic sig(input int w, input int g);
    return (w == 0) ? sw[g] : (w == 1) ? up[g] : dn[g];
  endfunction : sig

  task automatic wait_for(input int w, input int g, input logic lvl, output int n);
    n = 0;
    any_dn = 1'b0;
    @(negedge clk_i);
    while (sig(w, g) !== lvl) begin
      any_dn |= dn[g];
      n++;
      if (n > 3000) time_out();
      @(negedge clk_i);
    end
  endtask : wait_for

  task automatic clear();
    @(posedge clk_i);
    clear_faults <= 1'b1;
    @(posedge clk_i);
    clear_faults <= 1'b0;
  endtask : clear

  task automatic t_defaults();
    logic [7:0] codes [4] = '{8'h60, 8'h61, 8'h64, 8'h65};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        rd_chk(codes[i], p[0], (i == 0 && p == 0) ? 16'hD280 : 16'hCA80);
      end
      rd_chk(8'h78, p[0], 16'h0040);
    end
  endtask : t_defaults

  task automatic t_regs();
    logic [15:0] d;
    i_host.write_cmd(8'h61, 1'b0, 16'hC832);
    rd_chk(8'h61, 1'b0, 16'hC832);
    rd_chk(8'h61, 1'b1, 16'hCA80);
    i_host.write_cmd(8'h78, 1'b1, 16'h00FF);
    rd_chk(8'h78, 1'b1, 16'h0042);
    rd_chk(8'h78, 1'b0, 16'h0040);
    i_host.busy_read(1'b0, d);
    check(d, 16'h0040);
    rd_chk(8'h78, 1'b0, 16'h00C0);
    rd_chk(8'h60, 1'b0, 16'hD280);
    rd_chk(8'h62, 1'b0, 16'h0000);
    clear();
    rd_chk(8'h78, 1'b1, 16'h0040);
    rd_chk(8'h78, 1'b0, 16'h0040);
  endtask : t_regs

  task automatic t_faults();
    int b [6] = '{5, 4, 3, 2, 1, 0};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      flt[i] <= 2'b10;
      @(posedge clk_i);
      flt[i] <= 2'b00;
      rd_chk(8'h78, 1'b1, 16'h0040 | (16'h0001 << b[i]));
      rd_chk(8'h78, 1'b0, 16'h0040);
      clear();
      rd_chk(8'h78, 1'b1, 16'h0040);
    end
  endtask : t_faults

  // Second output on its reset timings: 5 ms is 640 units, two cycles each
  task automatic t_page1();
    int n;
    @(posedge clk_i);
    enable[1] <= 1'b1;
    wait_for(1, 1, 1'b1, n);
    near(n, 1280);
    check(16'({sw[0], up[0], dn[0]}), 16'h0000);
    wait_for(1, 1, 1'b0, n);
    near(n, 1280);
    check(16'(sw[1]), 16'h0001);
    @(posedge clk_i);
    enable[1] <= 1'b0;
    wait_for(2, 1, 1'b1, n);
    near(n, 1280);
    wait_for(2, 1, 1'b0, n);
    near(n, 1280);
    check(16'(sw[1]), 16'h0000);
  endtask : t_page1

  task automatic t_seq(input logic mp, input logic [15:0] fall, input int up_e, input int dn_e);
    int n;
    @(posedge clk_i);
    multi_phase <= mp;
    i_host.write_cmd(8'h65, 1'b0, fall);
    @(posedge clk_i);
    enable[0] <= 1'b1;
    wait_for(1, 0, 1'b1, n);
    near(n, 40);
    wait_for(1, 0, 1'b0, n);
    near(n, up_e);
    check(16'(sw[0]), 16'h0001);
    rd_chk(8'h78, 1'b0, 16'h0000);
    @(posedge clk_i);
    enable[0] <= 1'b0;
    wait_for((dn_e == 0) ? 0 : 2, 0, (dn_e == 0) ? 1'b0 : 1'b1, n);
    near(n, 32);
    check(16'(any_dn | ((dn_e == 0) ? dn[0] : 1'b0)), 16'h0000);
    if (dn_e != 0) begin
      check(16'(sw[0]), 16'h0001);
      wait_for(2, 0, 1'b0, n);
      near(n, dn_e);
    end
    rd_chk(8'h78, 1'b0, 16'h0040);
  endtask : t_seq

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    time_out();
  end

  initial begin
    rst_i = 1'b1;
    clear_faults = 1'b0;
    multi_phase = 1'b0;
    enable = 2'b00;
    mp_gain = 16'hC81E;
    foreach (flt[i]) flt[i] = 2'b00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_regs();
    t_faults();
    t_page1();
    i_host.write_cmd(8'h60, 1'b0, 16'hC814);
    i_host.write_cmd(8'h61, 1'b0, 16'hC80A);
    i_host.write_cmd(8'h64, 1'b0, 16'hC810);
    // Fall of 64 units is the lowest that still ramps
    t_seq(1'b0, 16'hC850, 20, 160);
    t_seq(1'b0, 16'hC840, 20, 128);
    t_seq(1'b0, 16'hC83F, 20, 0);
    t_seq(1'b1, 16'hC850, 60, 0);
    wrap_up();
  end
endmodule : oos_seq_tb_top
